/* File: hdl/ewdto_pkg.sv */
package ewdto_pkg;
  localparam int unsigned ADDR_W        = 32;
  localparam int unsigned DATA_W        = 64;
  localparam int unsigned TAG_W         = 3;
  localparam int unsigned RD_DEPTH      = 4;
  localparam int unsigned WR_DEPTH      = 4;
  localparam int unsigned BEATS_W       = 4;
  localparam logic [3:0]  BEATS_RST     = 4'h0;
  localparam logic [7:0]  SLOT_RST      = 8'h00;

  typedef enum logic {
    EWDTO_KIND_READ,
    EWDTO_KIND_WRITE
  } ewdto_kind_t;

  typedef enum logic [1:0] {
    EWDTO_ST_IDLE,
    EWDTO_ST_WRITE,
    EWDTO_ST_READ
  } ewdto_state_t;
endpackage : ewdto_pkg

/* File: hdl/ewdto_tag_queue.sv */
`timescale 1ns/1ps
// in-order queue of tags with a registered head output
module ewdto_tag_queue #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clock,    // bus clock
  input  wire logic             sys_rst,  // async reset, active high
  input  wire logic             push,     // append entry
  input  wire logic [WIDTH-1:0] push_data, // entry to append
  input  wire logic             pop,      // drop head entry
  output logic                  full,     // no room left
  output logic                  empty,    // nothing held
  output logic [WIDTH-1:0]      head      // oldest entry, registered
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    rd_q, rd_d, wr_q, wr_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic [WIDTH-1:0] head_q, head_d;

  assign full  = (cnt_q == (PW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign head  = head_q;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  always_comb begin
    logic do_push;
    logic do_pop;
    do_push = push && !full;
    do_pop  = pop && !empty;
    mem_d   = mem_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    cnt_d   = cnt_q;
    if (do_push) begin
      mem_d[wr_q] = push_data;
      wr_d        = nxt(wr_q);
    end
    if (do_pop) begin
      rd_d = nxt(rd_q);
    end
    case ({do_push, do_pop})
      2'b10:   cnt_d = cnt_q + 1'b1;
      2'b01:   cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
    head_d = mem_d[rd_d];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q   <= '0;
      wr_q   <= '0;
      cnt_q  <= '0;
      head_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      cnt_q  <= cnt_d;
      head_q <= head_d;
      mem_q  <= mem_d;
    end
  end
endmodule : ewdto_tag_queue

/* File: hdl/ewdto_beat_ctr.sv */
`timescale 1ns/1ps
// counts acknowledged beats of one data tenure
module ewdto_beat_ctr #(
  parameter int unsigned W = 4
) (
  input  wire logic         clock,   // bus clock
  input  wire logic         sys_rst, // async reset, active high
  input  wire logic         start,   // load beat count
  input  wire logic [W-1:0] beats,   // beats in tenure, at least one
  input  wire logic         ack,     // one beat acknowledged
  output logic              last     // final beat acknowledged now
);
  import ewdto_pkg::*;

  logic [W-1:0] left_q, left_d;

  assign last = ack && (left_q == W'(1));

  always_comb begin
    left_d = left_q;
    if (start) begin
      left_d = beats;
    end else if (ack && left_q != '0) begin
      left_d = left_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      left_q <= W'(BEATS_RST);
    end else begin
      left_q <= left_d;
    end
  end
endmodule : ewdto_beat_ctr

/* File: hdl/ewdto_sequencer.sv */
// Function
// - write-ahead qualifier runs next pending write first
// - writes keep their original queue order
// - writes only pass own pending reads
// - otherwise data tenures follow address order
// - enveloped write: busy, drive data, release busy
// - next grant after envelope completes the read
// - foreign tenures tolerated between any steps
// - qualifier without pending read changes nothing
// - write set fixed at address grant
// - several writes may envelope one read
// - bidirectional signals released between tenures
`timescale 1ns/1ps
module ewdto_sequencer #(
  parameter int unsigned DATA_W   = ewdto_pkg::DATA_W,
  parameter int unsigned TAG_W    = ewdto_pkg::TAG_W,
  parameter int unsigned RD_DEPTH = ewdto_pkg::RD_DEPTH,
  parameter int unsigned WR_DEPTH = ewdto_pkg::WR_DEPTH,
  parameter int unsigned BEATS_W  = ewdto_pkg::BEATS_W
) (
  input  wire logic               clock,                 // bus clock, 40 MHz
  input  wire logic               sys_rst,               // async reset, active high
  // address tenures completed by this device
  input  wire logic               addr_done,             // address tenure ends, with or without retry
  input  wire logic               address_retry_request, // retry on this address tenure
  input  wire ewdto_pkg::ewdto_kind_t addr_kind,         // kind of completing tenure
  input  wire logic [TAG_W-1:0]   addr_tag,              // tag of completing tenure
  input  wire logic [BEATS_W-1:0] addr_beats,            // beats of its data tenure
  input  wire logic               address_tenure_grant,  // address grant, seen for queue snapshot
  input  wire logic [WR_DEPTH-1:0] wr_queued,            // write queue slots holding data
  // data bus arbitration
  input  wire logic               data_tenure_grant,     // qualified data grant
  input  wire logic               write_ahead_qualifier, // write-only qualifier
  input  wire logic               data_tenure_busy_in,   // busy wire level seen
  output logic                    data_tenure_busy_out,  // busy driven value
  output logic                    data_tenure_busy_oe,   // busy driven
  // data transfer
  input  wire logic               beat_ack,              // beat acknowledge
  input  wire logic [DATA_W-1:0]  data_in,               // data wires seen
  input  wire logic [DATA_W-1:0]  wr_data,               // write data for current beat
  output logic [DATA_W-1:0]       data_out,              // data driven value
  output logic                    data_oe,               // data driven
  output logic                    wr_beat_req,           // write beat taken, next data please
  output logic [TAG_W-1:0]        cur_tag,               // tag of running data tenure
  output logic                    cur_is_write,          // running tenure is a write
  output logic                    tenure_done,           // data tenure finished, one cycle
  output logic                    rd_valid,              // read beat latched, one cycle
  output logic [DATA_W-1:0]       rd_data,               // latched read data
  output logic                    wr_snapshot_vld,       // queue snapshot taken
  output logic [WR_DEPTH-1:0]     wr_snapshot,           // writes fixed for this address
  output logic                    rd_pending,            // a read data tenure waits
  output logic                    wr_pending             // a write data tenure waits
);
  import ewdto_pkg::*;

  localparam int unsigned QW = 1 + TAG_W + BEATS_W;
  localparam int unsigned SW = $clog2(WR_DEPTH + 1);

  ewdto_state_t      st_q, st_d;
  logic [TAG_W-1:0]  tag_q, tag_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic              oe_q, oe_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic              rvld_q, rvld_d;
  logic [WR_DEPTH-1:0] snap_q, snap_d;
  logic              snap_vld_q, snap_vld_d;
  logic              done_q, done_d;

  logic              ord_push, ord_pop, ord_full, ord_empty;
  logic [QW-1:0]     ord_head;
  logic              wq_push, wq_pop, wq_full, wq_empty;
  logic [QW-1:0]     wq_head;
  logic              rq_push, rq_pop, rq_full, rq_empty;
  logic [QW-1:0]     rq_head;
  logic              grant_q;
  logic              take_grant, go_write, go_read, start;
  logic [BEATS_W-1:0] beats_sel;
  logic              last_beat;
  logic [QW-1:0]     entry;

  // envelope bookkeeping and overflow guard
  logic [SW-1:0]     skip_q, skip_d;
  logic              drain;
  logic              room;

  assign entry = {addr_kind == EWDTO_KIND_WRITE, addr_tag, addr_beats};

  // only tenures that finished without retry get a data tenure; one whose
  // kind queue is full is dropped from both queues alike, so the order
  // queue never names an entry that the kind queues never took
  assign room     = (addr_kind == EWDTO_KIND_WRITE) ? !wq_full : !rq_full;
  assign ord_push = addr_done && !address_retry_request && room;
  assign wq_push  = ord_push && addr_kind == EWDTO_KIND_WRITE;
  assign rq_push  = ord_push && addr_kind == EWDTO_KIND_READ;

  // program-order queue: decides the normal sequence
  ewdto_tag_queue #(.WIDTH(QW), .DEPTH(RD_DEPTH + WR_DEPTH)) u_order (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .push     (ord_push),
    .push_data(entry),
    .pop      (ord_pop),
    .full     (ord_full),
    .empty    (ord_empty),
    .head     (ord_head)
  );

  // write-only queue: oldest write first, never reordered
  ewdto_tag_queue #(.WIDTH(QW), .DEPTH(WR_DEPTH)) u_writes (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .push     (wq_push),
    .push_data(entry),
    .pop      (wq_pop),
    .full     (wq_full),
    .empty    (wq_empty),
    .head     (wq_head)
  );

  ewdto_tag_queue #(.WIDTH(QW), .DEPTH(RD_DEPTH)) u_reads (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .push     (rq_push),
    .push_data(entry),
    .pop      (rq_pop),
    .full     (rq_full),
    .empty    (rq_empty),
    .head     (rq_head)
  );

  // grant edge: a fresh qualified grant while busy is low on the wire and we are idle
  assign take_grant = data_tenure_grant && !grant_q && st_q == EWDTO_ST_IDLE
                      && !data_tenure_busy_in && !ord_empty && !drain;

  // a write that ran enveloped still sits in the order queue; once it
  // reaches the head it is dropped unrun, and no grant is taken meanwhile
  // so that a stale head never picks the wrong kind
  assign drain = !ord_empty && ord_head[QW-1] && skip_q != '0;

  // qualifier looked at only with a taken grant; only effective when a
  // read heads the order and a write waits behind it
  always_comb begin
    go_write = 1'b0;
    go_read  = 1'b0;
    if (take_grant) begin
      if (write_ahead_qualifier && !wq_empty) begin
        go_write = 1'b1;
      end else if (ord_head[QW-1]) begin
        go_write = 1'b1;
      end else begin
        go_read = 1'b1;
      end
    end
  end

  assign start     = go_write || go_read;
  assign beats_sel = go_write ? wq_head[BEATS_W-1:0] : rq_head[BEATS_W-1:0];

  ewdto_beat_ctr #(.W(BEATS_W)) u_beats (
    .clock  (clock),
    .sys_rst(sys_rst),
    .start  (start),
    .beats  (beats_sel),
    .ack    (beat_ack && st_q != EWDTO_ST_IDLE),
    .last   (last_beat)
  );

  // pops: kind queue at start, order queue removes the same tag
  assign wq_pop  = go_write;
  assign rq_pop  = go_read;
  // order queue pops its head when the head is what ran, and when drain
  // drops a write that already ran ahead of a read; an enveloped write
  // leaves the read at the head and is remembered by the skip count
  // instead, as writes never pass one another
  assign ord_pop = drain || go_read || (go_write && ord_head[QW-1]);

  // count of writes run ahead of an older read of our own; a count is
  // enough, because both queues keep writes in one order, so the skipped
  // ones are always the oldest writes still in the order queue
  // it is not held to the write depth: each skipped write was popped from the
  // write queue, which can then take more, and drain undoes one per cycle once the read has run
  // the qualifier only lands here with a taken grant
  always_comb begin
    skip_d = skip_q;
    if (go_write && !ord_head[QW-1]) begin
      skip_d = skip_q + 1'b1;
    end else if (drain) begin
      skip_d = skip_q - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      skip_q <= '0;
    end else begin
      skip_q <= skip_d;
    end
  end

  always_comb begin
    st_d       = st_q;
    tag_d      = tag_q;
    dout_d     = dout_q;
    oe_d       = oe_q;
    rdat_d     = rdat_q;
    rvld_d     = 1'b0;
    done_d     = 1'b0;
    snap_d     = snap_q;
    snap_vld_d = 1'b0;
    // queue contents captured at every address grant, of either kind
    if (address_tenure_grant) begin
      snap_d     = wr_queued;
      snap_vld_d = 1'b1;
    end
    case (st_q)
      EWDTO_ST_IDLE: begin
        oe_d = 1'b0;
        if (go_write) begin
          st_d   = EWDTO_ST_WRITE;
          tag_d  = wq_head[QW-2 -: TAG_W];
          dout_d = wr_data;
          oe_d   = 1'b1;
        end else if (go_read) begin
          st_d  = EWDTO_ST_READ;
          tag_d = rq_head[QW-2 -: TAG_W];
        end
      end
      EWDTO_ST_WRITE: begin
        // follows the supplier, which moves to the next beat one cycle after
        // each acknowledge; the bus must leave at least one cycle between
        // write beats for the new word to stand on the wires
        dout_d = wr_data;
        if (last_beat) begin
          st_d   = EWDTO_ST_IDLE;
          oe_d   = 1'b0;
          done_d = 1'b1;
        end
      end
      EWDTO_ST_READ: begin
        if (beat_ack) begin
          rdat_d = data_in;
          rvld_d = 1'b1;
        end
        if (last_beat) begin
          st_d   = EWDTO_ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = EWDTO_ST_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= EWDTO_ST_IDLE;
      tag_q      <= '0;
      dout_q     <= '0;
      oe_q       <= 1'b0;
      rdat_q     <= '0;
      rvld_q     <= 1'b0;
      done_q     <= 1'b0;
      snap_q     <= WR_DEPTH'(SLOT_RST);
      snap_vld_q <= 1'b0;
      grant_q    <= 1'b0;
    end else begin
      st_q       <= st_d;
      tag_q      <= tag_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
      rdat_q     <= rdat_d;
      rvld_q     <= rvld_d;
      done_q     <= done_d;
      snap_q     <= snap_d;
      snap_vld_q <= snap_vld_d;
      grant_q    <= data_tenure_grant;
    end
  end

  // busy held for the whole tenure, released after
  assign data_tenure_busy_out = st_q != EWDTO_ST_IDLE;
  assign data_tenure_busy_oe  = st_q != EWDTO_ST_IDLE;
  assign data_out        = dout_q;
  assign data_oe         = oe_q;
  assign wr_beat_req     = st_q == EWDTO_ST_WRITE && beat_ack;
  assign cur_tag         = tag_q;
  assign cur_is_write    = st_q == EWDTO_ST_WRITE;
  assign tenure_done     = done_q;
  assign rd_valid        = rvld_q;
  assign rd_data         = rdat_q;
  assign wr_snapshot_vld = snap_vld_q;
  assign wr_snapshot     = snap_q;
  assign rd_pending      = !rq_empty;
  assign wr_pending      = !wq_empty;
endmodule : ewdto_sequencer

/* File: test/ewdto_seq_sva.sv */
`timescale 1ns/1ps
module ewdto_seq_sva #(
  parameter int unsigned DATA_W   = 64,
  parameter int unsigned WR_DEPTH = 4
) (
  input wire logic                clock,                 // clock
  input wire logic                sys_rst,               // reset
  input wire logic                data_tenure_grant,     // grant
  input wire logic                write_ahead_qualifier, // qualifier
  input wire logic                data_tenure_busy_in,   // busy wire
  input wire logic                data_tenure_busy_out,  // busy value
  input wire logic                data_tenure_busy_oe,   // busy driven
  input wire logic                beat_ack,              // ack
  input wire logic [DATA_W-1:0]   data_in,               // data wires
  input wire logic                data_oe,               // data driven
  input wire logic                cur_is_write,          // write running
  input wire logic                tenure_done,           // done pulse
  input wire logic                rd_valid,              // read latched
  input wire logic [DATA_W-1:0]   rd_data,               // read data
  input wire logic                rd_pending,            // read waits
  input wire logic                wr_pending,            // write waits
  input wire logic                address_tenure_grant,  // address grant
  input wire logic [WR_DEPTH-1:0] wr_queued,             // queue slots
  input wire logic                wr_snapshot_vld,       // snapshot taken
  input wire logic [WR_DEPTH-1:0] wr_snapshot            // snapshot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_edge;
    data_tenure_grant && !$past(data_tenure_grant);
  endsequence
  sequence s_take;
    s_edge ##0 (!data_tenure_busy_oe && !data_tenure_busy_in && !tenure_done
                && (rd_pending || wr_pending));
  endsequence

  a_grant_busy_answer: assert property (s_take |=> data_tenure_busy_oe && data_tenure_busy_out)
    else $error("busy not driven after grant");
  a_qual_runs_write: assert property (
    s_take ##0 (write_ahead_qualifier && wr_pending) |=> cur_is_write && data_oe)
    else $error("qualified grant did not run a write");
  a_read_without_write: assert property (s_take ##0 !wr_pending |=> !cur_is_write)
    else $error("write ran with none pending");
  a_busy_in_refused: assert property (
    s_edge ##0 (data_tenure_busy_in && !data_tenure_busy_oe) |=> !data_tenure_busy_oe)
    else $error("grant taken while bus busy");
  a_stray_qual_ignored: assert property (
    write_ahead_qualifier && !data_tenure_grant && !data_tenure_busy_oe |=> !data_tenure_busy_oe)
    else $error("qualifier alone started a tenure");
  a_data_oe_scope: assert property (data_oe |-> data_tenure_busy_oe && cur_is_write)
    else $error("data driven outside write tenure");
  a_done_after_ack: assert property (
    tenure_done |-> $past(beat_ack) && $past(data_tenure_busy_oe) && !data_tenure_busy_oe)
    else $error("done without final ack");
  a_read_latch: assert property (
    rd_valid |-> $past(beat_ack && !cur_is_write) && rd_data == $past(data_in))
    else $error("read data not latched at ack");
  a_snapshot_fix: assert property (
    address_tenure_grant |=> wr_snapshot_vld && wr_snapshot == $past(wr_queued))
    else $error("queue snapshot wrong");
endmodule : ewdto_seq_sva

/* File: test/ewdto_arbiter_model.sv */
`timescale 1ns/1ps
module ewdto_arbiter_model (
  input  wire logic       clock,                 // clock
  input  wire logic       sys_rst,               // reset
  input  wire logic       go,                    // one grant wanted
  input  wire logic       qual,                  // qualifier with it
  input  wire logic       stray,                 // qualifier alone
  input  wire logic [3:0] slow,                  // wait per beat
  input  wire logic       data_tenure_busy_oe,   // device busy
  output logic            data_tenure_grant,     // grant
  output logic            write_ahead_qualifier, // qualifier
  output logic            beat_ack,              // ack
  output logic [63:0]     data_in                // data wires
);
  logic        wq;
  logic [15:0] n;
  assign write_ahead_qualifier = wq | stray;
  initial begin
    data_tenure_grant = 1'b0;
    wq = 1'b0;
    beat_ack = 1'b0;
    data_in = 64'h0;
    n = 16'h0;
    forever begin
      @(posedge clock);
      if (go && !sys_rst) begin
        #2 data_tenure_grant = 1'b1;
        wq = qual;
        @(posedge clock);
        #2 data_tenure_grant = 1'b0;
        wq = 1'b0;
        while (data_tenure_busy_oe) begin
          repeat (slow) begin
            @(posedge clock);
            #2;
          end
          beat_ack = 1'b1;
          data_in = {16'hDA7A, 32'h0, n};
          n = n + 16'h0001;
          @(posedge clock);
          #2 beat_ack = 1'b0;
          data_in = ~data_in; // lines no longer valid
          // at least one idle cycle between beats
          if (slow == 4'h0 && data_tenure_busy_oe) begin
            @(posedge clock);
            #2;
          end
        end
      end
    end
  end
endmodule : ewdto_arbiter_model

/* File: test/enveloped_write_data_tenure_order_tb_top.sv */
`timescale 1ns/1ps
module enveloped_write_data_tenure_order_tb_top;
  import ewdto_pkg::*;
  logic        clock, sys_rst, addr_done, address_retry_request, address_tenure_grant;
  ewdto_kind_t addr_kind;
  logic [2:0]  addr_tag, cur_tag;
  logic [3:0]  addr_beats, wr_queued, wr_snapshot, slow;
  logic        data_tenure_grant, write_ahead_qualifier, data_tenure_busy_in;
  logic        data_tenure_busy_out, data_tenure_busy_oe, beat_ack, data_oe, wr_beat_req;
  logic        cur_is_write, tenure_done, rd_valid, wr_snapshot_vld, rd_pending, wr_pending;
  logic        go, qual, stray, other_busy, busy_q;
  logic [63:0] data_in, wr_data, data_out, rd_data, exp_rd;
  logic [15:0] wbeat;
  logic [4:0]  tlog[$];
  int          num_errors, comparisons;

  assign data_tenure_busy_in = other_busy | (data_tenure_busy_oe & data_tenure_busy_out);
  assign wr_data = {48'hC0DE_0000_0000, wbeat};

  ewdto_sequencer dut_u (.clock(clock), .sys_rst(sys_rst), .addr_done(addr_done),
    .address_retry_request(address_retry_request), .addr_kind(addr_kind),
    .addr_tag(addr_tag), .addr_beats(addr_beats), .address_tenure_grant(address_tenure_grant),
    .wr_queued(wr_queued), .data_tenure_grant(data_tenure_grant),
    .write_ahead_qualifier(write_ahead_qualifier), .data_tenure_busy_in(data_tenure_busy_in),
    .data_tenure_busy_out(data_tenure_busy_out), .data_tenure_busy_oe(data_tenure_busy_oe),
    .beat_ack(beat_ack), .data_in(data_in), .wr_data(wr_data), .data_out(data_out),
    .data_oe(data_oe), .wr_beat_req(wr_beat_req), .cur_tag(cur_tag),
    .cur_is_write(cur_is_write), .tenure_done(tenure_done), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_snapshot_vld(wr_snapshot_vld), .wr_snapshot(wr_snapshot),
    .rd_pending(rd_pending), .wr_pending(wr_pending));

  ewdto_arbiter_model arb_u (.clock(clock), .sys_rst(sys_rst), .go(go), .qual(qual),
    .stray(stray), .slow(slow), .data_tenure_busy_oe(data_tenure_busy_oe),
    .data_tenure_grant(data_tenure_grant), .write_ahead_qualifier(write_ahead_qualifier),
    .beat_ack(beat_ack), .data_in(data_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic void chk(input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endfunction : chk

  // tenure order log plus data checks at each beat
  always @(posedge clock) begin
    busy_q <= data_tenure_busy_oe;
    if (data_tenure_busy_oe && !busy_q) tlog.push_back({1'b1, cur_is_write, cur_tag});
    if (beat_ack && data_tenure_busy_oe && !cur_is_write) exp_rd <= data_in;
    if (rd_valid) chk(exp_rd, rd_data);
    if (beat_ack && data_oe) chk(wr_data, data_out);
    if (sys_rst) wbeat <= 16'h0000;
    else if (wr_beat_req) wbeat <= wbeat + 16'h0001;
  end

  task automatic addr(input logic k, input logic [2:0] t, input logic [3:0] b, input logic rt);
    addr_kind = ewdto_kind_t'(k);
    addr_tag = t;
    addr_beats = b;
    address_retry_request = rt;
    addr_done = 1'b1;
    @(posedge clock);
    #2 addr_done = 1'b0;
    address_retry_request = 1'b0;
    @(posedge clock);
    #2;
  endtask : addr

  task automatic grant(input logic q, input logic k, input logic [2:0] t);
    int n;
    go = 1'b1;
    qual = q;
    @(posedge clock);
    #2 go = 1'b0;
    n = 0;
    while (tenure_done !== 1'b1 && n < 60) begin
      @(posedge clock);
      #2 n++;
    end
    chk({59'h0, 1'b1, k, t}, {59'h0, (tlog.size() != 0) ? tlog.pop_front() : 5'h00});
    @(posedge clock);
    #2;
  endtask : grant

  task automatic t_in_order;
    addr(1'b0, 3'h1, 4'h1, 1'b0);
    addr(1'b1, 3'h2, 4'h1, 1'b0);
    addr(1'b0, 3'h3, 4'h1, 1'b1);
    grant(1'b0, 1'b0, 3'h1);
    grant(1'b0, 1'b1, 3'h2);
    chk(64'h0, {62'h0, rd_pending, wr_pending});
  endtask : t_in_order

  task automatic t_envelope;
    slow = 4'h2;
    addr(1'b0, 3'h4, 4'h2, 1'b0);
    wr_queued = 4'h3;
    address_tenure_grant = 1'b1;
    @(posedge clock);
    #2 address_tenure_grant = 1'b0;
    chk(64'h13, {59'h0, wr_snapshot_vld, wr_snapshot});
    addr(1'b1, 3'h5, 4'h1, 1'b0);
    addr(1'b1, 3'h6, 4'h2, 1'b0);
    grant(1'b1, 1'b1, 3'h5);
    grant(1'b1, 1'b1, 3'h6);
    grant(1'b0, 1'b0, 3'h4);
    slow = 4'h0;
  endtask : t_envelope

  task automatic t_foreign;
    addr(1'b0, 3'h7, 4'h1, 1'b0);
    other_busy = 1'b1;
    go = 1'b1;
    @(posedge clock);
    #2 go = 1'b0;
    repeat (4) @(posedge clock);
    #2 chk(64'h0, {63'h0, data_tenure_busy_oe});
    other_busy = 1'b0;
    stray = 1'b1;
    repeat (3) @(posedge clock);
    #2 stray = 1'b0;
    chk(64'h0, {63'h0, data_tenure_busy_oe});
    grant(1'b0, 1'b0, 3'h7);
  endtask : t_foreign

  task automatic t_no_read;
    addr(1'b1, 3'h2, 4'h1, 1'b0);
    addr(1'b1, 3'h3, 4'h1, 1'b0);
    grant(1'b1, 1'b1, 3'h2);
    grant(1'b1, 1'b1, 3'h3);
    addr(1'b0, 3'h1, 4'h1, 1'b0);
    grant(1'b1, 1'b0, 3'h1);
  endtask : t_no_read

  task automatic complete_run;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  initial begin
    sys_rst = 1'b1;
    {addr_done, address_retry_request, address_tenure_grant, go, qual, stray} = 6'h0;
    {other_busy, addr_tag, addr_beats, wr_queued, slow} = 16'h0000;
    addr_kind = EWDTO_KIND_READ;
    repeat (20) @(posedge clock);
    #2 sys_rst = 1'b0;
    chk(64'h0, {62'h0, data_tenure_busy_oe, data_oe});
    t_in_order;
    t_envelope;
    t_foreign;
    t_no_read;
    complete_run;
  end

  initial begin
    #(25 * 3000);
    num_errors++;
    complete_run;
  end
endmodule : enveloped_write_data_tenure_order_tb_top

bind ewdto_sequencer ewdto_seq_sva #(.DATA_W(DATA_W), .WR_DEPTH(WR_DEPTH)) sva_u (
  .clock(clock), .sys_rst(sys_rst), .data_tenure_grant(data_tenure_grant),
  .write_ahead_qualifier(write_ahead_qualifier), .data_tenure_busy_in(data_tenure_busy_in),
  .data_tenure_busy_out(data_tenure_busy_out), .data_tenure_busy_oe(data_tenure_busy_oe),
  .beat_ack(beat_ack), .data_in(data_in), .data_oe(data_oe), .cur_is_write(cur_is_write),
  .tenure_done(tenure_done), .rd_valid(rd_valid), .rd_data(rd_data),
  .rd_pending(rd_pending), .wr_pending(wr_pending),
  .address_tenure_grant(address_tenure_grant), .wr_queued(wr_queued),
  .wr_snapshot_vld(wr_snapshot_vld), .wr_snapshot(wr_snapshot));
